// >>> adsq_top.sv
// converter sequencer control and status registers
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "adsq_cfg.svh"
module adsq_top #(
   parameter int DATA_W = 8
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [7:0] rdata,
   input wire logic low_power,
   input wire logic [DATA_W-1:0] core_result,
   output logic [3:0] channel_select,
   output logic analog_input_disable,
   output logic ladder_on,
   output logic sample_go,
   output logic conv_done_irq
);
   // result path is eight bits wide
   if (DATA_W != 8) begin : g_width_check
      $error("adsq_top supports DATA_W of 8 only");
   end

   function automatic logic [10:0] conv_len(input logic [2:0] code);
      unique case (code)
         3'h0: conv_len = `ADSQ_CYC_T0;
         3'h2: conv_len = `ADSQ_CYC_T2;
         3'h3: conv_len = `ADSQ_CYC_T3;
         3'h4: conv_len = `ADSQ_CYC_T4;
         3'h5: conv_len = `ADSQ_CYC_T5;
         3'h6: conv_len = `ADSQ_CYC_T6;
         default: conv_len = `ADSQ_CYC_T0;
      endcase
   endfunction

   logic [7:0] ctrl_a;
   logic [7:0] ctrl_b;
   logic [7:0] result;
   logic eoc;
   logic busy;
   logic [10:0] cnt;
   adsq_pkg::adsq_state_t state;
   logic wr_a;
   logic wr_b;
   logic start_req;
   logic start_ok;
   logic finish;

   assign wr_a = wr_stb && !low_power && addr == `ADSQ_OFS_CTRL_A;
   assign wr_b = wr_stb && !low_power && addr == `ADSQ_OFS_CTRL_B;
   assign start_req = wr_a && wdata[`ADSQ_BIT_START]; // R1
   assign start_ok = start_req && state == adsq_pkg::ADSQ_IDLE;
   assign finish = state == adsq_pkg::ADSQ_CONV && cnt == 11'h001; // R24

   // control register a; start bit never stored
   always_ff @(posedge clock) begin
      if (srst || low_power) begin
         ctrl_a <= `ADSQ_RST_CTRL_A; // R7
      end else if (wr_a) begin
         ctrl_a <= {1'b0, wdata[6:0]}; // R2
      end
   end

   always_ff @(posedge clock) begin
      if (srst || low_power) begin
         ctrl_b <= `ADSQ_RST_CTRL_B; // R8
      end else if (wr_b) begin
         ctrl_b <= wdata;
      end
   end

   // sequencer; restarts while busy are ignored
   always_ff @(posedge clock) begin
      if (srst || low_power) begin
         state <= adsq_pkg::ADSQ_IDLE; // R23
         cnt <= 11'h000;
         busy <= 1'b0; // R18
      end else begin
         unique case (state)
            adsq_pkg::ADSQ_IDLE: begin
               if (start_req) begin
                  state <= adsq_pkg::ADSQ_CONV;
                  cnt <= conv_len(ctrl_b[3:1]); // R12
                  busy <= 1'b1; // R18
               end
            end
            adsq_pkg::ADSQ_CONV: begin
               cnt <= cnt - 11'h001; // R24
               if (finish) begin
                  state <= adsq_pkg::ADSQ_IDLE;
                  busy <= 1'b0; // R18
               end
            end
         endcase
      end
   end

   // result and end flag; completion wins over a result read
   always_ff @(posedge clock) begin
      if (srst || low_power) begin
         result <= 8'h00; // R23
         eoc <= 1'b0;
      end else if (finish) begin
         result <= core_result; // R20 R21
         eoc <= 1'b1; // R21
      end else if (start_ok) begin
         eoc <= 1'b0; // R22
      end else if (rd_stb && addr == `ADSQ_OFS_RESULT) begin
         eoc <= 1'b0; // R16
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         conv_done_irq <= 1'b0;
         sample_go <= 1'b0;
      end else begin
         conv_done_irq <= finish && !low_power; // R21
         sample_go <= start_ok && !low_power;
      end
   end

   // pin-facing copies
   always_ff @(posedge clock) begin
      if (srst) begin
         channel_select <= 4'h0;
         analog_input_disable <= 1'b1;
         ladder_on <= 1'b0;
      end else begin
         channel_select <= ctrl_a[3:0]; // R4
         analog_input_disable <= ctrl_a[`ADSQ_BIT_AIN_DIS];
         ladder_on <= !low_power && (ctrl_b[`ADSQ_BIT_LADDER] ||
            (busy && !finish) || start_ok); // R11
      end
   end

   // register read port
   always_ff @(posedge clock) begin
      if (srst) begin
         rdata <= 8'h00;
      end else if (rd_stb) begin
         unique case (addr)
            `ADSQ_OFS_CTRL_A: rdata <= ctrl_a;
            `ADSQ_OFS_CTRL_B: rdata <= {2'b00, ctrl_b[5:0]}; // R14
            `ADSQ_OFS_RESULT: rdata <= result;
            `ADSQ_OFS_STATUS: rdata <= {2'b00, eoc, busy, 4'h0}; // R15 R19
            default: rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end
endmodule
`default_nettype wire

// >>> adsq_cfg.svh
// register map, reset values and timing counts for the converter sequencer
//
// Contract
// R1: writing one to start bit 7 begins conversion of selected channel
// R2: start bit clears itself once the conversion has begun
// R3: software sets analog input disable when no analog input used
// R4: channel select bits 3..0 pick inputs zero to five; rest reserved
// R5: software changes channel only while busy reads zero
// R6: software never restarts during a conversion; waits for end flag
// R7: low-power entry resets control register a; writes ignored meanwhile
// R8: low-power entry resets control register b; software rewrites it
// R9: software writes one to bit 5, zero to bit 6 of register a
// R10: software writes zero to bit 0, one to bit 4 of register b
// R11: ladder on only while converting unless ladder_always_on is set
// R12: time code gives 39,78,156,312,624,1248 clocks; 001,111 reserved
// R13: software avoids prohibited time and frequency combinations
// R14: bits 7 and 6 of register b read undefined
// R15: status bit 5 is end flag, set once conversion completes
// R16: reading result register clears the end flag
// R17: software reads status before result
// R18: busy bit 4 set at start, cleared at finish or low-power entry
// R19: status bits 7, 6, 3..0 read unstable
// R20: result register holds most recent completed conversion; code clears it to zero on low-power entry
// R21: completion stores result, sets end flag, pulses done interrupt
// R22: restart clears end flag, old result kept until new completion
// R23: low-power entry aborts conversion; no automatic restart
// R24: count selected clocks with busy high, then finish in one cycle
`ifndef ADSQ_CFG_SVH
`define ADSQ_CFG_SVH
`define ADSQ_OFS_CTRL_A 8'h0E
`define ADSQ_OFS_CTRL_B 8'h0F
`define ADSQ_OFS_RESULT 8'h20
`define ADSQ_OFS_STATUS 8'h21
`define ADSQ_RST_CTRL_A 8'h10
`define ADSQ_RST_CTRL_B 8'h10
`define ADSQ_BIT_START 7
`define ADSQ_BIT_AIN_DIS 4
`define ADSQ_BIT_LADDER 5
`define ADSQ_BIT_EOC 5
`define ADSQ_BIT_BUSY 4
`define ADSQ_LAST_CHAN 4'h5
`define ADSQ_CYC_T0 11'h027
`define ADSQ_CYC_T2 11'h04E
`define ADSQ_CYC_T3 11'h09C
`define ADSQ_CYC_T4 11'h138
`define ADSQ_CYC_T5 11'h270
`define ADSQ_CYC_T6 11'h4E0
`endif

// >>> adsq_pkg.sv
// types for the converter sequencer
package adsq_pkg;
   typedef enum logic [1:0] {
      ADSQ_IDLE = 2'b01,
      ADSQ_CONV = 2'b10
   } adsq_state_t;
endpackage

// >>> adsq_top_asserts.sv
// port checker for the converter sequencer
`timescale 1ns/1ns
`default_nettype none
module adsq_chk (
   input wire logic clock,
   input wire logic srst,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [7:0] rdata,
   input wire logic low_power,
   input wire logic [3:0] channel_select,
   input wire logic ladder_on,
   input wire logic sample_go,
   input wire logic conv_done_irq
);
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   sequence s_go;
      wr_stb && addr == 8'h0E && wdata[7] ##1 sample_go;
   endsequence
   property p_cause; sample_go |-> $past(wr_stb && wdata[7]); endproperty
   a_cause: assert property (p_cause) else $error("bad start");
   property p_once; s_go |=> !sample_go; endproperty
   a_once: assert property (p_once) else $error("long start");
   property p_lad; sample_go |-> ladder_on; endproperty
   a_lad: assert property (p_lad) else $error("ladder off");
   property p_chan;
      wr_stb && addr == 8'h0E && !low_power |->
         ##2 channel_select == $past(wdata[3:0], 2);
   endproperty
   a_chan: assert property (p_chan) else $error("channel");
   property p_lp;
      low_power [*3] |-> !ladder_on && channel_select == 4'h0;
   endproperty
   a_lp: assert property (p_lp) else $error("low power");
   property p_irq; conv_done_irq |=> !conv_done_irq; endproperty
   a_irq: assert property (p_irq) else $error("long irq");
   property p_len; s_go |-> (!conv_done_irq) [*8]; endproperty
   a_len: assert property (p_len) else $error("early end");
   property p_rd; rd_stb && addr == 8'h0E |=> !rdata[7]; endproperty
   a_rd: assert property (p_rd) else $error("start bit read");
endmodule
bind adsq_top adsq_chk i_chk (.*);
`default_nettype wire

// >>> adsq_core.sv
// behavioural analog core model
`timescale 1ns/1ns
`default_nettype none
module adsq_core (
   input wire logic clock,
   input wire logic sample_go,
   input wire logic conv_done_irq,
   input wire logic [7:0] level,
   output logic [7:0] core_result
);
   logic on = 1'b0;
   logic [7:0] junk = 8'h5A;
   always_ff @(posedge clock) begin
      junk <= junk + 8'h3B;
      on <= sample_go | (on & ~conv_done_irq);
   end
   assign core_result = on ? level : junk;
endmodule
`default_nettype wire

// >>> adsq_top_tb_top.sv
// self-checking bench for the converter sequencer
`timescale 1ns/1ns
`default_nettype none
module adsq_top_tb_top;
   logic clock, srst, wr_stb, rd_stb, low_power, sample_go, conv_done_irq;
   logic analog_input_disable, ladder_on;
   logic [7:0] addr, wdata, rdata, core_result, level;
   logic [7:0] model_q[$];
   logic [3:0] channel_select, ch;
   logic [31:0] seed = 32'h4075FD79;
   int miscompares = 0, compares = 0, k;
   int cyc[8] = '{39, 39, 78, 156, 312, 624, 1248, 39};
   time t0;
   adsq_top i_dut (.*);
   adsq_core i_core (.*);
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic chk(input string n, input logic [11:0] e,
      input logic [11:0] s);
      compares++;
      if (s !== e) begin
         miscompares++;
         $display("wrong value %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge clock);
      wr_stb <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rd(input logic [7:0] a, e, m, input string n);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clock);
      rd_stb <= 1'b0;
      @(posedge clock);
      chk(n, e & m, rdata & m);
   endtask
   task automatic close_out;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   initial begin
      #400000;
      miscompares++;
      close_out;
   end
   initial begin
      srst = 1'b1;
      model_q.push_back(8'h00);
      {wr_stb, rd_stb, low_power, addr, wdata, level} = '0;
      repeat (16) @(posedge clock);
      srst <= 1'b0;
      @(posedge clock);
      rd(8'h0E, 8'h10, 8'hFF, "ctrl_a");
      rd(8'h0F, 8'h10, 8'h3F, "ctrl_b");
      rd(8'h30, 8'h00, 8'hFF, "unmapped");
      for (int i = 0; i < 8; i++) begin
         seed = xs(seed);
         ch = 4'(seed[15:8] % 8'h06);
         level <= seed[7:0];
         wr(8'h0F, {2'b00, seed[20], 1'b1, i[2:0], 1'b0});
         wr(8'h0E, {4'hA, ch});
         t0 = $time - 20;
         rd(8'h21, 8'h10, 8'h30, "busy");
         rd(8'h20, model_q[$], 8'hFF, "old result");
         chk("channel", 12'(ch), 12'(channel_select));
         chk("ain dis", 12'h000, 12'(analog_input_disable));
         k = 0;
         while (conv_done_irq !== 1'b1 && k < 2000) begin
            @(posedge clock);
            k++;
         end
         chk("length", 12'(cyc[i] + 1), 12'(($time - t0) / 20));
         rd(8'h21, 8'h20, 8'h30, "end flag");
         chk("ladder", 12'(seed[20]), 12'(ladder_on));
         model_q.push_back(seed[7:0]);
      end
      rd(8'h20, model_q[$], 8'hFF, "result");
      rd(8'h21, 8'h00, 8'h30, "cleared");
      wr(8'h0F, 8'h30);
      wr(8'h0E, 8'hA3);
      low_power <= 1'b1;
      wr(8'h0E, 8'h25);
      repeat (2) @(posedge clock);
      low_power <= 1'b0;
      repeat (60) @(posedge clock);
      rd(8'h0E, 8'h10, 8'hFF, "lp ctrl_a");
      rd(8'h0F, 8'h10, 8'h3F, "lp ctrl_b");
      rd(8'h21, 8'h00, 8'h30, "lp status");
      chk("lp ladder", 12'h000, 12'(ladder_on));
      chk("lp ain dis", 12'h001, 12'(analog_input_disable));
      close_out;
   end
endmodule
`default_nettype wire
